/* rtl/bae_exec.sv */
module bae_exec (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// Wishbone slave
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_cyc_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Port pins and timer
	input  wire logic [7:0]  portPins,
	output logic      [7:0]  portLatch,
	output logic             prescalerClear
);

	localparam int AW = bae_pkg::ADDR_W;
	localparam int DW = bae_pkg::DATA_W;

	bae_pkg::bae_phase_t phase;
	bae_pkg::bae_kind_t  kind;

	logic [DW-1:0]  pinMeta;
	logic [DW-1:0]  pinLevel;
	logic           extEnable;
	logic           prescAssigned;
	logic [15:0]    instrReg;
	logic [DW-1:0]  acc;
	logic [4:0]     flags;
	logic [3:0]     bank;
	logic [AW-1:0]  indexBase;
	logic [20:0]    pc;
	logic [7:0]     gotoLow;
	logic           expectSecond;
	logic           flushing;
	logic [AW-1:0]  effAddr;
	logic [DW-1:0]  operand;
	logic [DW-1:0]  sum;
	logic [4:0]     sumFlags;
	logic [AW-1:0]  dataAddr;
	logic [DW-1:0]  dataShadow;
	logic           shadowLoad;
	logic [31:0]    cycleCount;
	logic           wbReq;
	logic           wbWr;
	logic [31:0]    wbMask;
	logic           instrStart;
	logic           memWe;
	logic [AW-1:0]  memAddr;
	logic [DW-1:0]  memWdata;
	logic [DW-1:0]  memRdata;
	logic [31:0]    rdVal;
	logic [12:0]    addOut;

	function automatic bae_pkg::bae_kind_t decodeKind(input logic [15:0] w,
	                                                  input logic expect2);
		if (w[15:12] == bae_pkg::OPC_SECOND) begin
			decodeKind = expect2 ? bae_pkg::K_GOTO2 : bae_pkg::K_IDLE;
		end else if (w[15:8] == bae_pkg::OPC_ADD_LIT) begin
			decodeKind = bae_pkg::K_ADD_LIT;
		end else if (w[15:10] == bae_pkg::OPC_ADD_FILE) begin
			decodeKind = bae_pkg::K_ADD_FILE;
		end else if (w[15:8] == bae_pkg::OPC_GOTO_FIRST) begin
			decodeKind = bae_pkg::K_GOTO1;
		end else if (w[15:11] == bae_pkg::OPC_BRANCH) begin
			decodeKind = bae_pkg::K_BRANCH;
		end else begin
			decodeKind = bae_pkg::K_IDLE;
		end
	endfunction : decodeKind

	function automatic logic [AW-1:0] effAddrFn(input logic [15:0] w, input logic [3:0] bsel,
	                                            input logic [AW-1:0] base, input logic ext);
		logic [7:0] f;
		f = w[7:0];
		if (!w[bae_pkg::BIT_BANKED] && ext && f < bae_pkg::ACCESS_SPLIT) begin
			effAddrFn = base + {4'h0, f};
		end else if (!w[bae_pkg::BIT_BANKED]) begin
			effAddrFn = (f < bae_pkg::ACCESS_SPLIT) ? {4'h0, f} : {bae_pkg::ACCESS_HIGH, f};
		end else begin
			effAddrFn = {bsel, f};
		end
	endfunction : effAddrFn

	// Returns {flags, sum}
	function automatic logic [12:0] addFn(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] half;
		logic [4:0] fl;
		full = {1'b0, a} + {1'b0, b};
		half = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		fl[bae_pkg::FLAG_C]  = full[8];
		fl[bae_pkg::FLAG_HALF] = half[4];
		fl[bae_pkg::FLAG_Z]  = (full[7:0] == 8'h00);
		fl[bae_pkg::FLAG_BAD] = (a[7] == b[7]) && (full[7] != a[7]);
		fl[bae_pkg::FLAG_N]  = full[7];
		addFn = {fl, full[7:0]};
	endfunction : addFn

	assign wbReq      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wbWr       = wbReq & wb_we_i;
	assign instrStart = wbWr && wb_adr_i == bae_pkg::OFF_INSTR && phase == bae_pkg::PH_IDLE;
	assign wbMask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign addOut     = addFn(acc, operand);

	// Pin levels cross in from outside through two flops
	always_ff @(posedge core_clk) begin
		pinMeta  <= portPins;
		pinLevel <= pinMeta;
	end

	// Memory port: the core owns it in Q1 and Q4, software only while idle
	always_comb begin
		memWe    = 1'b0;
		memAddr  = dataAddr;
		memWdata = wb_dat_i[7:0];
		unique case (phase)
			bae_pkg::PH_Q1: begin
				memAddr = effAddrFn(instrReg, bank, indexBase, extEnable);
			end
			bae_pkg::PH_Q4: begin
				memAddr  = effAddr;
				memWdata = sum;
				memWe    = kind == bae_pkg::K_ADD_FILE && instrReg[bae_pkg::BIT_DEST];
			end
			bae_pkg::PH_IDLE: begin
				if (wbWr && wb_adr_i == bae_pkg::OFF_DATA_ADDR) begin
					memAddr = wb_dat_i[AW-1:0];
				end
				memWe = wbWr && wb_adr_i == bae_pkg::OFF_DATA_VAL && wb_sel_i[0];
			end
			default: begin
			end
		endcase
	end

	bae_file_ram #(
		.AW(AW),
		.DW(DW)
	) u_ram (
		.clk  (core_clk),
		.we   (memWe),
		.addr (memAddr),
		.wdata(memWdata),
		.rdata(memRdata)
	);

	// Four phases per instruction cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			phase    <= bae_pkg::PH_IDLE;
			flushing <= 1'b0;
		end else begin
			unique case (phase)
				bae_pkg::PH_IDLE: begin
					if (instrStart) begin
						phase <= bae_pkg::PH_Q1;
					end
				end
				bae_pkg::PH_Q1: phase <= bae_pkg::PH_Q2;
				bae_pkg::PH_Q2: phase <= bae_pkg::PH_Q3;
				bae_pkg::PH_Q3: phase <= bae_pkg::PH_Q4;
				bae_pkg::PH_Q4: begin
					// Branch only: one more cycle that does nothing
					if (kind == bae_pkg::K_BRANCH && !flushing) begin
						flushing <= 1'b1;
						phase    <= bae_pkg::PH_Q1;
					end else begin
						flushing <= 1'b0;
						phase    <= bae_pkg::PH_IDLE;
					end
				end
			endcase
		end
	end

	// Decode, operand fetch and arithmetic
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			kind     <= bae_pkg::K_IDLE;
			effAddr  <= '0;
			operand  <= 8'h00;
			sum      <= 8'h00;
			sumFlags <= 5'h00;
		end else begin
			if (phase == bae_pkg::PH_Q1) begin
				kind    <= flushing ? bae_pkg::K_IDLE : decodeKind(instrReg, expectSecond);
				effAddr <= effAddrFn(instrReg, bank, indexBase, extEnable);
			end
			if (phase == bae_pkg::PH_Q2) begin
				if (kind == bae_pkg::K_ADD_LIT) begin
					operand <= instrReg[7:0];
				end else if (effAddr == bae_pkg::PORT_ADDR) begin
					operand <= pinLevel;
				end else begin
					operand <= memRdata;
				end
			end
			if (phase == bae_pkg::PH_Q3) begin
				sum      <= addOut[7:0];
				sumFlags <= addOut[12:8];
			end
		end
	end

	// Destination write and program flow in Q4
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			acc          <= bae_pkg::RST_ACC;
			flags        <= bae_pkg::RST_FLAGS;
			pc           <= bae_pkg::RST_PC;
			gotoLow      <= 8'h00;
			expectSecond <= 1'b0;
			cycleCount   <= '0;
		end else if (phase == bae_pkg::PH_Q4) begin
			cycleCount   <= cycleCount + 32'h1;
			expectSecond <= kind == bae_pkg::K_GOTO1;
			if (kind == bae_pkg::K_ADD_LIT || kind == bae_pkg::K_ADD_FILE) begin
				flags <= sumFlags;
			end
			if (kind == bae_pkg::K_ADD_LIT
			    || (kind == bae_pkg::K_ADD_FILE && !instrReg[bae_pkg::BIT_DEST])) begin
				acc <= sum;
			end
			if (!flushing) begin
				unique case (kind)
					bae_pkg::K_GOTO1: begin
						gotoLow <= instrReg[7:0];
						pc      <= pc + 21'h2;
					end
					bae_pkg::K_GOTO2: pc <= {instrReg[11:0], gotoLow, 1'b0};
					bae_pkg::K_BRANCH: begin
						pc <= pc + 21'h2 + {{9{instrReg[10]}}, instrReg[10:0], 1'b0};
					end
					default: pc <= pc + 21'h2;
				endcase
			end
		end else if (wbWr && wb_adr_i == bae_pkg::OFF_ACC && phase == bae_pkg::PH_IDLE) begin
			acc <= (acc & ~wbMask[7:0]) | (wb_dat_i[7:0] & wbMask[7:0]);
		end
	end

	// Timer prescaler clear pulse, one clock
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prescalerClear <= 1'b0;
		end else begin
			prescalerClear <= memWe && phase == bae_pkg::PH_Q4
			                  && memAddr == bae_pkg::TIMER0_ADDR && prescAssigned;
		end
	end

	// Output latch mirrors writes to the port register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			portLatch <= 8'h00;
		end else if (memWe && memAddr == bae_pkg::PORT_ADDR) begin
			portLatch <= memWdata;
		end
	end

	// Software-written control registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			extEnable     <= 1'b0;
			prescAssigned <= 1'b0;
			instrReg      <= bae_pkg::RST_INSTR;
			bank          <= bae_pkg::RST_BANK;
			indexBase     <= bae_pkg::RST_INDEX;
			dataAddr      <= '0;
		end else if (wbWr) begin
			unique case (wb_adr_i)
				bae_pkg::OFF_CTRL: begin
					if (wb_sel_i[0]) begin
						extEnable     <= wb_dat_i[bae_pkg::CTRL_EXT];
						prescAssigned <= wb_dat_i[bae_pkg::CTRL_PRESC];
					end
				end
				bae_pkg::OFF_INSTR: begin
					// A word sent while busy is dropped
					if (instrStart) begin
						instrReg <= (instrReg & ~wbMask[15:0]) | (wb_dat_i[15:0] & wbMask[15:0]);
					end
				end
				bae_pkg::OFF_BANK: begin
					if (wb_sel_i[0]) begin
						bank <= wb_dat_i[3:0];
					end
				end
				bae_pkg::OFF_INDEX: begin
					indexBase <= (indexBase & ~wbMask[AW-1:0]) | (wb_dat_i[AW-1:0] & wbMask[AW-1:0]);
				end
				bae_pkg::OFF_DATA_ADDR: begin
					dataAddr <= (dataAddr & ~wbMask[AW-1:0]) | (wb_dat_i[AW-1:0] & wbMask[AW-1:0]);
				end
				default: begin
				end
			endcase
		end
	end

	// Byte read-back through the shadow; only fresh while idle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			shadowLoad <= 1'b0;
			dataShadow <= 8'h00;
		end else begin
			shadowLoad <= wbWr && wb_adr_i == bae_pkg::OFF_DATA_ADDR && phase == bae_pkg::PH_IDLE;
			if (shadowLoad) begin
				dataShadow <= memRdata;
			end
		end
	end

	always_comb begin
		rdVal = 32'h00000000;
		unique case (wb_adr_i)
			bae_pkg::OFF_CTRL:      rdVal = {30'h0, prescAssigned, extEnable};
			bae_pkg::OFF_INSTR:     rdVal = {16'h0, instrReg};
			bae_pkg::OFF_ACC:       rdVal = {24'h0, acc};
			bae_pkg::OFF_FLAGS:     rdVal = {27'h0, flags};
			bae_pkg::OFF_BANK:      rdVal = {28'h0, bank};
			bae_pkg::OFF_INDEX:     rdVal = {20'h0, indexBase};
			bae_pkg::OFF_STAT:      rdVal = {30'h0, expectSecond, phase != bae_pkg::PH_IDLE};
			bae_pkg::OFF_PC:        rdVal = {11'h0, pc};
			bae_pkg::OFF_DATA_ADDR: rdVal = {20'h0, dataAddr};
			bae_pkg::OFF_DATA_VAL:  rdVal = {24'h0, dataShadow};
			bae_pkg::OFF_CYCLES:    rdVal = cycleCount;
			default:                rdVal = 32'h00000000;
		endcase
	end

	// Every request answered one clock later, unmapped reads give zero
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wbReq;
			if (wbReq && !wb_we_i) begin
				wb_dat_o <= rdVal;
			end
		end
	end

endmodule : bae_exec

/* rtl/bae_pkg.sv */
// How it works
// - A port register modified from itself takes the pin levels as its source.
// - A result written to timer_zero_count clears its prescaler when it is assigned there.
// - A flow change or true test takes two instruction cycles, the second one idle; here only a branch gets the idle cycle, a goto's second word loads the pc.
// - A lone second word runs as idle_cycle_op unless its first word consumes it.
// - add_literal_to_accumulator (0000 1111 kkkk kkkk) adds the literal to the accumulator.
// - add_accumulator_to_file (0010 01da ffff ffff) with d=0 puts the sum in the accumulator.
// - With d=1 the sum goes back into the addressed file register.
// - With a=0 the file address falls in the fixed access bank.
// - With a=1 the bank_select_pointer picks the general_file_bank.
// - With the extended set on, a=0 and f at most 95, the address is index base plus f.
package bae_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;

	// Opcode fields
	localparam logic [7:0] OPC_ADD_LIT    = 8'h0F;
	localparam logic [5:0] OPC_ADD_FILE   = 6'h09;
	localparam logic [7:0] OPC_GOTO_FIRST = 8'hEF;
	localparam logic [3:0] OPC_SECOND     = 4'hF;
	localparam logic [4:0] OPC_BRANCH     = 5'h1A;
	localparam int         BIT_DEST       = 9;
	localparam int         BIT_BANKED     = 8;

	// Access bank split and special registers
	localparam logic [7:0]        ACCESS_SPLIT = 8'h60;
	localparam logic [3:0]        ACCESS_HIGH  = 4'hF;
	localparam logic [ADDR_W-1:0] PORT_ADDR    = 12'hF81;
	localparam logic [ADDR_W-1:0] TIMER0_ADDR  = 12'hFD6;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_INSTR     = 8'h04;
	localparam logic [7:0] OFF_ACC       = 8'h08;
	localparam logic [7:0] OFF_FLAGS     = 8'h0C;
	localparam logic [7:0] OFF_BANK      = 8'h10;
	localparam logic [7:0] OFF_INDEX     = 8'h14;
	localparam logic [7:0] OFF_STAT      = 8'h18;
	localparam logic [7:0] OFF_PC        = 8'h1C;
	localparam logic [7:0] OFF_DATA_ADDR = 8'h20;
	localparam logic [7:0] OFF_DATA_VAL  = 8'h24;
	localparam logic [7:0] OFF_CYCLES    = 8'h28;

	// Field positions
	localparam int CTRL_EXT   = 0;
	localparam int CTRL_PRESC = 1;
	localparam int STAT_BUSY  = 0;
	localparam int STAT_EXPECT = 1;
	localparam int FLAG_C     = 0;
	localparam int FLAG_HALF  = 1;
	localparam int FLAG_Z     = 2;
	localparam int FLAG_BAD   = 3;
	localparam int FLAG_N     = 4;

	// Reset values
	localparam logic [7:0]  RST_ACC   = 8'h00;
	localparam logic [4:0]  RST_FLAGS = 5'h00;
	localparam logic [3:0]  RST_BANK  = 4'h0;
	localparam logic [11:0] RST_INDEX = 12'h000;
	localparam logic [20:0] RST_PC    = 21'h000000;
	localparam logic [15:0] RST_INSTR = 16'h0000;

	typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} bae_phase_t;
	typedef enum logic [2:0] {K_IDLE, K_ADD_LIT, K_ADD_FILE, K_GOTO1, K_GOTO2, K_BRANCH} bae_kind_t;

endpackage : bae_pkg

/* rtl/bae_file_ram.sv */
module bae_file_ram #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	// Clock
	input  wire logic          clk,
	// Access port
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Read-first: a read in the write cycle returns the old byte
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule : bae_file_ram

/* tb/bae_exec_monitor.sv */
module bae_exec_monitor (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        sys_rst,
	// Wishbone slave
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic        wb_we_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_cyc_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Port and timer
	input wire logic [7:0]  portPins,
	input wire logic [7:0]  portLatch,
	input wire logic        prescalerClear
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] sinceInstr;
	logic [3:0] sinceWr;
	wire        takeWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// Saturating ages keep the effect windows bounded
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sinceInstr <= 4'hF;
			sinceWr    <= 4'hF;
		end else begin
			if (takeWr && wb_adr_i == bae_pkg::OFF_INSTR) begin
				sinceInstr <= 4'h0;
			end else if (sinceInstr != 4'hF) begin
				sinceInstr <= sinceInstr + 4'h1;
			end
			if (takeWr) begin
				sinceWr <= 4'h0;
			end else if (sinceWr != 4'hF) begin
				sinceWr <= sinceWr + 4'h1;
			end
		end
	end

	sequence reqTaken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence readFar;
		reqTaken ##0 (!wb_we_i && wb_adr_i > bae_pkg::OFF_CYCLES);
	endsequence

	ack_answer_a: assert property (reqTaken |=> wb_ack_o)
		else $error("ack missing after request");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	rdata_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
		else $error("read data moved without ack");
	unmapped_zero_a: assert property (readFar |=> wb_dat_o == 32'h00000000)
		else $error("unmapped read not zero");
	presc_pulse_a: assert property (prescalerClear |=> !prescalerClear)
		else $error("prescaler clear not a pulse");
	presc_cause_a: assert property (prescalerClear |-> sinceInstr inside {[3:8]})
		else $error("prescaler clear without instruction");
	latch_cause_a: assert property (!$stable(portLatch) |-> sinceWr <= 4'h8)
		else $error("port latch moved without a write");
endmodule : bae_exec_monitor

bind bae_exec bae_exec_monitor bae_exec_monitor_inst (
	.core_clk(core_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .portPins(portPins), .portLatch(portLatch),
	.prescalerClear(prescalerClear)
);

/* tb/bae_exec_bench.sv */
module bae_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk;
	logic        sys_rst;
	logic [7:0]  wbAdr;
	logic [31:0] wbDat;
	logic        wbWe;
	logic        wbStb;
	logic        wbCyc;
	logic [31:0] wbDatOut;
	logic        wbAck;
	logic [7:0]  portPins;
	logic [7:0]  portLatch;
	logic        prescalerClear;
	logic [31:0] rdv;
	logic [7:0]  v;
	logic [31:0] expQ[$];
	string       nameQ[$];
	int          nMismatch;
	int          compares;
	int          seed;
	int          pulses;
	logic [7:0]  regs[9] = '{bae_pkg::OFF_CTRL, bae_pkg::OFF_ACC, bae_pkg::OFF_FLAGS,
		bae_pkg::OFF_BANK, bae_pkg::OFF_INDEX, bae_pkg::OFF_STAT, bae_pkg::OFF_PC,
		bae_pkg::OFF_CYCLES, 8'h30};

	bae_exec bae_exec_inst (
		.core_clk(core_clk), .sys_rst(sys_rst), .wb_adr_i(wbAdr), .wb_dat_i(wbDat),
		.wb_sel_i(4'hF), .wb_we_i(wbWe), .wb_stb_i(wbStb), .wb_cyc_i(wbCyc),
		.wb_dat_o(wbDatOut), .wb_ack_o(wbAck), .portPins(portPins),
		.portLatch(portLatch), .prescalerClear(prescalerClear)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic testDone();
		if (nMismatch == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : testDone

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			nMismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Oldest note is compared at the ack edge that carries its data
	always @(posedge core_clk) begin
		if (prescalerClear === 1'b1) begin
			pulses++;
		end
		if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
			check(nameQ.pop_front(), wbDatOut, expQ.pop_front());
		end
	end

	task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		wbAdr <= ad;
		wbWe  <= w;
		wbDat <= d;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 40);
		if (n >= 40) begin
			nMismatch++;
		end
		rdv = wbDatOut;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge core_clk);
	endtask : bus

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		bus(ad, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string s);
		expQ.push_back(e);
		nameQ.push_back(s);
		bus(ad, 1'b0, 32'h00000000);
	endtask : rd

	task automatic run(input logic [15:0] op);
		int n;
		n = 0;
		wr(bae_pkg::OFF_INSTR, {16'h0000, op});
		do begin
			bus(bae_pkg::OFF_STAT, 1'b0, 32'h00000000);
			n++;
		end while (rdv[bae_pkg::STAT_BUSY] !== 1'b0 && n < 20);
		if (n >= 20) begin
			nMismatch++;
		end
	endtask : run

	function automatic logic [31:0] flg(input logic [7:0] x, input logic [7:0] y);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, x} + {1'b0, y};
		h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
		return {27'h0, s[7], x[7] == y[7] && s[7] != x[7], s[7:0] == 8'h00, h[4], s[8]};
	endfunction : flg

	task automatic addLit(input logic [7:0] x, input logic [7:0] k);
		wr(bae_pkg::OFF_ACC, {24'h0, x});
		run({8'h0F, k});
		rd(bae_pkg::OFF_ACC, {24'h0, 8'(x + k)}, "acc");
		rd(bae_pkg::OFF_FLAGS, flg(x, k), "flags");
	endtask : addLit

	task automatic addFile(input logic [7:0] x, input logic [11:0] loc, input logic [7:0] y,
		input logic [15:0] op);
		wr(bae_pkg::OFF_DATA_ADDR, {20'h0, loc});
		wr(bae_pkg::OFF_DATA_VAL, {24'h0, y});
		wr(bae_pkg::OFF_ACC, {24'h0, x});
		run(op);
		rd(bae_pkg::OFF_ACC, {24'h0, op[9] ? x : 8'(x + y)}, "acc");
		rd(bae_pkg::OFF_FLAGS, flg(x, y), "flags");
		wr(bae_pkg::OFF_DATA_ADDR, {20'h0, loc});
		rd(bae_pkg::OFF_DATA_VAL, {24'h0, op[9] ? 8'(x + y) : y}, "file");
	endtask : addFile

	task automatic doReset();
		sys_rst <= 1'b1;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
	endtask : doReset

	initial begin
		#200000;
		nMismatch++;
		testDone();
	end

	initial begin
		{wbAdr, wbDat, wbWe, wbStb, wbCyc, portPins} = '0;
		{nMismatch, compares, pulses} = '0;
		seed = 9;
		sys_rst = 1'b1;
		doReset();
		addLit(8'h10, 8'h15);
		addLit(8'hFF, 8'h01);
		addLit(8'h7F, 8'h01);
		repeat (3) addLit(8'($random(seed)), 8'($random(seed)));
		addFile(8'h17, 12'h005, 8'hC2, 16'h2405);
		wr(bae_pkg::OFF_BANK, 32'h2);
		addFile(8'($random(seed)), 12'h210, 8'($random(seed)), 16'h2710);
		addFile(8'($random(seed)), 12'hFA0, 8'($random(seed)), 16'h26A0);
		// Indexed boundary: 0x5F goes through the base, 0x60 does not
		wr(bae_pkg::OFF_CTRL, 32'h1);
		wr(bae_pkg::OFF_INDEX, 32'h300);
		addFile(8'($random(seed)), 12'h35F, 8'($random(seed)), 16'h265F);
		addFile(8'($random(seed)), 12'hF60, 8'($random(seed)), 16'h2660);
		// Latch holds ones so a latch-sourced sum would differ from a pin-sourced one
		wr(bae_pkg::OFF_DATA_ADDR, 32'hF81);
		wr(bae_pkg::OFF_DATA_VAL, 32'hFF);
		v = 8'($random(seed)) & 8'h7F;
		portPins <= v;
		repeat (3) @(posedge core_clk);
		wr(bae_pkg::OFF_ACC, 32'h1);
		run(16'h2681);
		check("latch", {24'h0, portLatch}, {24'h0, 8'(v + 8'h01)});
		wr(bae_pkg::OFF_CTRL, 32'h2);
		run(16'h26D6);
		run(16'h24D6);
		wr(bae_pkg::OFF_CTRL, 32'h0);
		run(16'h26D6);
		check("pulses", pulses, 32'h1);
		doReset();
		wr(8'h30, 32'hFFFFFFFF);
		wr(bae_pkg::OFF_PC, 32'h1234);
		foreach (regs[i]) begin
			rd(regs[i], 32'h0, "reset");
		end
		run(16'hF123);
		rd(bae_pkg::OFF_PC, 32'h2, "pc");
		rd(bae_pkg::OFF_CYCLES, 32'h1, "cycles");
		run(16'hD000);
		rd(bae_pkg::OFF_CYCLES, 32'h3, "cycles");
		rd(bae_pkg::OFF_PC, 32'h4, "pc");
		run(16'hEF10);
		rd(bae_pkg::OFF_STAT, 32'h2, "stat");
		run(16'hF002);
		rd(bae_pkg::OFF_PC, 32'h420, "pc");
		testDone();
	end
endmodule : bae_exec_bench
